/* File: bench/fetch_pipeline_sequencer_test.sv */
// self-checking bench for the fetch pipeline sequencer
// assumes fps_pkg and the program memory model; memory shrunk to 1K words to reach wraparound
`timescale 1ns/100ps
module fetch_pipeline_sequencer_test;
    import fps_pkg::*;
    localparam int WORDS = 1024;
    logic                mclk_in   = 1'b0;
    logic                arst_n_in = 1'b0;
    logic [INSTR_W-1:0]  prog_data_in;
    logic                branch_in = 1'b0;
    logic [PC_W-1:0]     branch_target_in = 13'h0000;
    logic                int_req_in = 1'b0;
    logic [PC_W-1:0]     prog_addr_out;
    fps_phases_t         phases_out;
    fps_exec_t           exec_out;
    logic [PC_W-1:0]     pc_out;
    int                  num_errors = 0;
    int                  tests_run  = 0;

    always #50 mclk_in = ~mclk_in;

    fps_sequencer #(.MEM_WORDS(WORDS)) dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .prog_data_in(prog_data_in), .branch_in(branch_in), .branch_target_in(branch_target_in),
        .int_req_in(int_req_in), .prog_addr_out(prog_addr_out), .phases_out(phases_out),
        .exec_out(exec_out), .pc_out(pc_out));
    fps_prog_mem #(.MEM_WORDS(WORDS)) mem (.addr_in(prog_addr_out), .data_out(prog_data_in));

    task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc;
        @(posedge mclk_in);
        #10;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one instruction cycle: v says whether the word at address a executes; br/tgt redirect at phase_four
    task automatic step(input logic v, input int a, input logic br, input logic [12:0] tgt);
        int n;
        n = 0;
        while (phases_out.phase_two !== 1'b1 && n < 8)
        begin
            cyc;
            n++;
        end
        chk("exec_valid", 14'(exec_out.exec_valid), 14'(v));
        if (v)
        begin
            chk("instr", exec_out.instr, {1'b1, 13'(a % WORDS)});
            chk("data_read", 14'(exec_out.data_read), 14'h0001);
            chk("pc", 14'(pc_out), 14'((a + 2) % WORDS));
            chk("prog_addr", 14'(prog_addr_out), 14'((a + 1) % WORDS));
        end
        cyc;
        chk("phase_three", 14'(phases_out), 14'h0002);
        cyc;
        chk("phase_four", 14'(phases_out), 14'h0001);
        chk("data_write", 14'(exec_out.data_write), 14'(v));
        branch_in = br;
        branch_target_in = tgt;
        cyc;
        branch_in = 1'b0;
        chk("phase_one", 14'(phases_out), 14'h0008);
    endtask

    task automatic t_reset;
        chk("reset pc", 14'(pc_out), 14'h0000);
        chk("reset valid", 14'(exec_out.exec_valid), 14'h0000);
        chk("reset phase", 14'(phases_out), 14'h0001);
        arst_n_in = 1'b1;
        step(1'b0, 0, 1'b0, 13'h0000);
        step(1'b1, 0, 1'b0, 13'h0000);
    endtask

    // redirect past the 1K top: target wraps, the fetched word is dropped
    task automatic t_branch;
        step(1'b1, 1, 1'b1, 13'h1407);
        step(1'b0, 0, 1'b1, 13'h0200); // branch with nothing executing is ignored
        step(1'b1, 7, 1'b1, 13'h03ff);
        step(1'b0, 0, 1'b0, 13'h0000);
        step(1'b1, 1023, 1'b0, 13'h0000);
        step(1'b1, 0, 1'b0, 13'h0000);
    endtask

    // interrupt wins over a branch in the same cycle
    task automatic t_interrupt;
        int_req_in = 1'b1;
        cyc;
        int_req_in = 1'b0;
        step(1'b1, 1, 1'b1, 13'h0100);
        step(1'b0, 0, 1'b0, 13'h0000);
        step(1'b1, 4, 1'b0, 13'h0000);
        step(1'b1, 5, 1'b0, 13'h0000);
    endtask

    initial
    begin
        repeat (12) @(posedge mclk_in);
        #10;
        t_reset;
        t_branch;
        t_interrupt;
        arst_n_in = 1'b0;
        cyc;
        t_reset;
        conclude;
    end

    // about 18 instruction cycles (some 71 clocks) of work; allow well over that
    initial
    begin
        #(100 * 600);
        num_errors++;
        conclude;
    end
endmodule

/* File: bench/fps_prog_mem.sv */
// program memory model standing behind the fetch sequencer
// assumes a read that settles within the fetch cycle, long before phase_four
`timescale 1ns/100ps
module fps_prog_mem
    import fps_pkg::*;
#(
    parameter int MEM_WORDS = 1024
)
(
    input  wire logic [PC_W-1:0]    addr_in,
    output logic [INSTR_W-1:0]      data_out
);
    // each word carries its own wrapped address, so a wrong fetch shows in the executed word
    assign data_out = {1'b1, addr_in & PC_W'(MEM_WORDS - 1)};
endmodule

/* File: hdl/fps_sequencer.sv */
// fetch and execute sequencer: four-phase clocking, program counter, pipeline flush
// assumes the datapath reports a branch target during phase_four of the execution cycle
//
// Contract
// - input clock divided into four phases
// - program counter increments in phase one
// - fetched word captured at phase four
// - decode and execute over phases two-four
// - data read phase two, write phase four
// - fetch overlaps execute, one per cycle
// - branches take two cycles, flush fetched
// - program counter is thirteen bits wide
// - memory size 1K, 2K, 4K or 8K
// - addresses above implemented top wrap around
// - reset starts execution at address zero
// - interrupt transfers control to address four
`timescale 1ns/100ps

module fps_sequencer
    import fps_pkg::*;
#(
    parameter int MEM_WORDS = MEM_WORDS_DEF
)
(
    input  wire logic                mclk_in,
    input  wire logic                arst_n_in,
    input  wire logic [INSTR_W-1:0]  prog_data_in,
    input  wire logic                branch_in,
    input  wire logic [PC_W-1:0]     branch_target_in,
    input  wire logic                int_req_in,
    output logic [PC_W-1:0]          prog_addr_out,
    output fps_phases_t              phases_out,
    output fps_exec_t                exec_out,
    output logic [PC_W-1:0]          pc_out
);

    localparam int ADDR_BITS = $clog2(MEM_WORDS);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if ((1 << ADDR_BITS) != MEM_WORDS || MEM_WORDS < 1024 || MEM_WORDS > 8192)
    begin : g_bad_size
        $error("MEM_WORDS must be 1024, 2048, 4096 or 8192");
    end

    // wraparound: upper bits are dropped above the implemented top
    function automatic logic [PC_W-1:0] wrap_addr(input logic [PC_W-1:0] a);
        logic [PC_W-1:0] m;
        m = PC_W'(MEM_WORDS - 1);
        return a & m;
    endfunction

    // ------------------------------------------------------------
    // phase divider
    // ------------------------------------------------------------
    fps_phase_t phase;

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            phase <= FPS_PHASE_FOUR;
        else
            phase <= fps_phase_t'(phase + 2'h1);
    end

    always_comb
    begin
        phases_out.phase_one   = (phase == FPS_PHASE_ONE);
        phases_out.phase_two   = (phase == FPS_PHASE_TWO);
        phases_out.phase_three = (phase == FPS_PHASE_THREE);
        phases_out.phase_four  = (phase == FPS_PHASE_FOUR);
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic            redirect;
    logic            exec_valid;
    logic            int_pend;

    // branch/interrupt decided at phase four so the new fetch starts next phase one
    assign redirect = (phase == FPS_PHASE_FOUR) && ((exec_valid && branch_in) || int_pend);

    always_comb
    begin
        // a pending interrupt wins over a branch taken in the same cycle
        next_pc = pc;
        if (redirect)
            next_pc = int_pend ? INT_VECTOR : wrap_addr(branch_target_in);
        else if (phase == FPS_PHASE_ONE)
            next_pc = wrap_addr(pc + 13'h0001);
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            pc <= RESET_VECTOR;
        else
            pc <= next_pc;
    end

    // fetch address is the pc before its phase-one increment, held through phase four;
    // taking next_pc here would skip the word at the reset vector and at every target
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            prog_addr_out <= RESET_VECTOR;
        else if (phase == FPS_PHASE_ONE)
            prog_addr_out <= pc;
    end

    assign pc_out = pc;

    // interrupt request held until the next phase four boundary
    // a request still high at the taking edge stays pending and is taken again
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            int_pend <= 1'b0;
        else if (int_req_in)
            int_pend <= 1'b1;
        else if (phase == FPS_PHASE_FOUR)
            int_pend <= 1'b0;
    end

    // ------------------------------------------------------------
    // instruction register and pipeline valid
    // ------------------------------------------------------------
    logic [INSTR_W-1:0] instr;
    logic               fetch_valid;

    // fetch_valid marks the word being fetched this cycle as usable
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            instr       <= NOP_WORD;
            exec_valid  <= 1'b0;
            fetch_valid <= 1'b0;
        end
        else if (phase == FPS_PHASE_FOUR)
        begin
            instr       <= prog_data_in;
            exec_valid  <= fetch_valid && !redirect;
            fetch_valid <= 1'b1;
        end
    end

    always_comb
    begin
        exec_out.instr      = instr;
        exec_out.exec_valid = exec_valid && (phase != FPS_PHASE_ONE);
        exec_out.data_read  = exec_valid && (phase == FPS_PHASE_TWO);
        exec_out.data_write = exec_valid && (phase == FPS_PHASE_FOUR);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_phase_cycle;
        @(posedge mclk_in) disable iff (!arst_n_in)
        phases_out.phase_one |=> phases_out.phase_two ##1 phases_out.phase_three ##1 phases_out.phase_four
            ##1 phases_out.phase_one;
    endproperty
    a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

    property p_pc_inc;
        @(posedge mclk_in) disable iff (!arst_n_in)
        phases_out.phase_one |=> pc == wrap_addr($past(pc) + 13'h0001);
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc did not increment in phase one");

    property p_ir_capture;
        @(posedge mclk_in) disable iff (!arst_n_in)
        phases_out.phase_four |=> instr == $past(prog_data_in);
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("instruction not captured");

    property p_exec_phases;
        @(posedge mclk_in) disable iff (!arst_n_in)
        exec_out.data_read |-> exec_out.exec_valid ##1 exec_out.exec_valid
            ##1 (exec_out.exec_valid && exec_out.data_write) ##1 !exec_out.exec_valid;
    endproperty
    a_exec_phases: assert property (p_exec_phases) else $error("execute in phase one");

    property p_data_rw;
        @(posedge mclk_in) disable iff (!arst_n_in)
        exec_out.data_read |=> ##1 exec_out.data_write;
    endproperty
    a_data_rw: assert property (p_data_rw) else $error("write did not follow read");

    property p_flush;
        @(posedge mclk_in) disable iff (!arst_n_in)
        redirect |=> !exec_valid [*4];
    endproperty
    a_flush: assert property (p_flush) else $error("fetched word not flushed");

    property p_wrap;
        @(posedge mclk_in) disable iff (!arst_n_in)
        ((pc | prog_addr_out) & ~PC_W'(MEM_WORDS - 1)) == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pc beyond implemented memory");

    property p_int_vector;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (redirect && int_pend) |=> pc == INT_VECTOR;
    endproperty
    a_int_vector: assert property (p_int_vector) else $error("interrupt vector wrong");

    property p_stream;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (phases_out.phase_four && fetch_valid && !redirect) |=> exec_valid;
    endproperty
    a_stream: assert property (p_stream) else $error("pipeline bubble without branch");

endmodule

/* File: include/fps_pkg.sv */
// package for the fetch pipeline sequencer: phases, vectors, sizes
// assumes a single clock domain and a program memory with one-phase read latency
package fps_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PC_W        = 13;
    localparam int INSTR_W     = 14;
    localparam int MEM_WORDS_DEF = 8192;

    // ------------------------------------------------------------
    // vectors and reset values
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0]    RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0]    INT_VECTOR   = 13'h0004;
    localparam logic [INSTR_W-1:0] NOP_WORD     = 14'h0000;
    localparam logic [1:0]         PHASE_RESET  = 2'h3;

    // ------------------------------------------------------------
    // phase encoding (divide by four)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FPS_PHASE_ONE,
        FPS_PHASE_TWO,
        FPS_PHASE_THREE,
        FPS_PHASE_FOUR
    } fps_phase_t;

    typedef struct packed {
        logic phase_one;
        logic phase_two;
        logic phase_three;
        logic phase_four;
    } fps_phases_t;

    // execution strobes toward the datapath
    typedef struct packed {
        logic                data_read;
        logic                data_write;
        logic                exec_valid;
        logic [INSTR_W-1:0]  instr;
    } fps_exec_t;

endpackage
